// ===== core/nco_map.svh
// Constant map for the numerically controlled oscillator core
`ifndef NCO_MAP_SVH
`define NCO_MAP_SVH

`define NCO_ACC_W        32
`define NCO_PHASE_W      14
`define NCO_OFS_W        5
`define NCO_DAC_W        10
`define NCO_ACC_ZERO     32'h0000_0000
`define NCO_OFS_ZERO     5'h00
`define NCO_TRUNC_LSB    18
`define NCO_OFS_SHIFT    9
`define NCO_CLK_PERIOD_NS 50
`define NCO_REF_MAX_PERIOD_NS 1000
`define NCO_MON_W        6
`define NCO_MON_LIMIT    6'((`NCO_REF_MAX_PERIOD_NS) / (`NCO_CLK_PERIOD_NS))
`define NCO_MON_ZERO     6'h00
`define NCO_DAC_MID      10'h200
`define NCO_DAC_MID_LO   10'h1FF
`define NCO_MAG_FULL     9'h1FF
`define NCO_DAC_MAX      10'h3FF
`define NCO_LAT_ZERO     2'h0
`define NCO_SYNC_ZERO    3'h0
`define NCO_MON_STEP     6'h01

`endif

// ===== core/nco_pkg.sv
// Types shared by the oscillator core and its cosine converter
package nco_pkg;
  typedef struct packed {
    logic [4:0]  phase_ofs;
    logic        power_down;
    logic [31:0] tuning_word;
  } nco_prog_t;

  typedef struct packed {
    logic       valid;
    logic [9:0] code;
  } nco_sample_t;
endpackage

// ===== core/nco_cos_conv.sv
// Phase to cosine amplitude converter with registered output
`timescale 1ns/1ps
`default_nettype none
`include "nco_map.svh"

module nco_cos_conv
  import nco_pkg::*;
(
  input  wire logic                     clk,      // System clock
  input  wire logic                     rstn,     // Sync reset, low
  input  wire logic [`NCO_PHASE_W-1:0]  phase,    // Truncated phase
  output logic      [`NCO_DAC_W-1:0]    cos_code  // Offset-binary cosine
);
  logic [12:0] half_reg;
  logic [11:0] quad;
  logic [23:0] sq;
  logic [8:0]  mag;
  logic [`NCO_DAC_W-1:0] code_next;

  // Parabolic approximation of each quarter wave, folded by symmetry
  always_comb begin
    half_reg  = phase[13] ? ~phase[12:0] : phase[12:0];
    quad      = half_reg[12] ? ~half_reg[11:0] : half_reg[11:0];
    sq        = 24'(quad) * 24'(quad);
    mag       = `NCO_MAG_FULL - sq[23:15];
    code_next = half_reg[12] ? (`NCO_DAC_MID_LO - 10'(mag))
                             : (`NCO_DAC_MID + 10'(mag));
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cos_code <= `NCO_DAC_MID;
    end else begin
      cos_code <= code_next; // R5
    end
  end

  a_cos_peak_zero: assert property (@(posedge clk) disable iff (!rstn) // R5
    phase == 14'h0000 |=> cos_code == `NCO_DAC_MAX)
    else $error("Zero phase did not give full-scale cosine");

  a_cos_half_min: assert property (@(posedge clk) disable iff (!rstn) // R5
    phase == 14'h2000 |=> cos_code < 10'h004)
    else $error("Half-cycle phase did not give minimum cosine");
endmodule
`default_nettype wire

// ===== core/nco_core.sv
// Phase accumulator, clock-rate monitor and sample stream of the NCO
`timescale 1ns/1ps
`default_nettype none
`include "nco_map.svh"

// Overview of operation
// R1: Accumulator adds the increment once per reference clock pulse.
// R2: Overflow carry is dropped; accumulator wraps modulo its range.
// R3: Tuning word itself is the per-pulse phase increment.
// R4: Tuning word and accumulator are 32 bits; fout = word*fref/2^32.
// R5: Upper 14 accumulator bits become a cosine amplitude each pulse.
// R6: One 10-bit cosine code goes to the converter per reference pulse.
// R7: New tuning word continues from the current phase, no jump.
// R8: Outside system must supply a reference clock of at least 1 MHz.
// R9: Reference clock slower than minimum forces power-down automatically.
// R10: Power-down ends as soon as the reference clock is fast again.
// R11: Controller should keep output below a third of reference rate.
// R12: Update strobe rising edge loads active words, clears load pointer.
// R13: Reset zeroes active words, pointer and power-down; input kept.
// R14: Synthesis advances on reference clock rising edges.
// R15: Phase offset word is added to the top five phase bits.
module nco_core
  import nco_pkg::*;
(
  input  wire logic             clk,                     // 20 MHz clock
  input  wire logic             rstn,                    // Sync reset, low
  input  wire logic             reference_clock_in,      // Reference pin
  input  wire logic             frequency_update_strobe, // Update pin
  input  wire nco_prog_t        prog_word,               // Assembled word
  output logic                  load_ptr_clear,          // Pointer to W0
  output nco_sample_t           dac_out,                 // Sample stream
  output logic                  power_down,              // In power-down
  output logic [`NCO_ACC_W-1:0] phase_acc                // Accumulator
);
  logic [2:0]               ref_sync_reg;
  logic [2:0]               upd_sync_reg;
  logic                     ref_edge;
  logic                     upd_edge;
  logic [`NCO_ACC_W-1:0]    ftw_reg;
  logic [`NCO_OFS_W-1:0]    ofs_reg;
  logic                     pd_bit_reg;
  logic [`NCO_ACC_W-1:0]    acc_reg;
  logic [`NCO_MON_W-1:0]    mon_cnt_reg;
  logic                     slow_reg;
  logic [`NCO_PHASE_W-1:0]  phase_next;
  logic [1:0]               lat_reg;
  logic [`NCO_DAC_W-1:0]    cos_code;

  function automatic logic rise(input logic [2:0] s);
    rise = s[1] & ~s[2];
  endfunction

  // Pins pass two flops before the edge detector looks at them
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ref_sync_reg <= `NCO_SYNC_ZERO;
      upd_sync_reg <= `NCO_SYNC_ZERO;
    end else begin
      ref_sync_reg <= {ref_sync_reg[1:0], reference_clock_in};
      upd_sync_reg <= {upd_sync_reg[1:0], frequency_update_strobe};
    end
  end

  assign ref_edge = rise(ref_sync_reg); // R14
  assign upd_edge = rise(upd_sync_reg);

  // Active tuning, phase and power-down words
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ftw_reg    <= `NCO_ACC_ZERO; // R13
      ofs_reg    <= `NCO_OFS_ZERO; // R13
      pd_bit_reg <= 1'b0;          // R13
    end else if (upd_edge) begin
      ftw_reg    <= prog_word.tuning_word; // R12
      ofs_reg    <= prog_word.phase_ofs;   // R12
      pd_bit_reg <= prog_word.power_down;  // R12
    end
  end

  // Pointer clears in reset and on every update edge
  assign load_ptr_clear = !rstn || upd_edge; // R12 R13

  // Clock-rate monitor: too many clk cycles between reference edges
  // The edge that clears the slow flag still sees power-down, so no step
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mon_cnt_reg <= `NCO_MON_ZERO;
      slow_reg    <= 1'b0;
    end else if (ref_edge) begin
      mon_cnt_reg <= `NCO_MON_ZERO;
      slow_reg    <= 1'b0; // R10
    end else if (mon_cnt_reg >= `NCO_MON_LIMIT) begin
      slow_reg    <= 1'b1; // R9
    end else begin
      mon_cnt_reg <= mon_cnt_reg + `NCO_MON_STEP;
    end
  end

  assign power_down = slow_reg || pd_bit_reg; // R9 R10

  // Accumulator: modulo 2^32, never reset by an update
  always_ff @(posedge clk) begin
    if (!rstn) begin
      acc_reg <= `NCO_ACC_ZERO; // R13
    end else if (ref_edge && !power_down) begin
      acc_reg <= acc_reg + ftw_reg; // R1 R2 R3 R4 R7
    end
  end

  assign phase_acc = acc_reg;

  // Truncate and apply the offset on the top five phase bits
  // Offset wraps inside the truncated phase, so it is a pure phase shift
  assign phase_next = acc_reg[`NCO_ACC_W-1:`NCO_TRUNC_LSB]
                    + {ofs_reg, {`NCO_OFS_SHIFT{1'b0}}}; // R5 R15

  nco_cos_conv nco_cos_conv_inst (
    .clk      (clk),
    .rstn     (rstn),
    .phase    (phase_next),
    .cos_code (cos_code)
  );

  // Valid follows the converter register, two cycles after the edge
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lat_reg <= `NCO_LAT_ZERO;
    end else begin
      lat_reg <= {lat_reg[0], ref_edge && !power_down};
    end
  end

  assign dac_out.valid = lat_reg[1]; // R6
  assign dac_out.code  = cos_code;   // R6

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_acc_step: assert property ( // R1
    ref_edge && !power_down |=> acc_reg == $past(acc_reg) + $past(ftw_reg))
    else $error("Accumulator did not add the tuning word");

  a_acc_hold: assert property ( // R7
    !ref_edge || power_down |=> acc_reg == $past(acc_reg))
    else $error("Accumulator moved without a reference edge");

  a_update_load: assert property ( // R12
    upd_edge |=> ftw_reg == $past(prog_word.tuning_word)
              && ofs_reg == $past(prog_word.phase_ofs))
    else $error("Update edge did not load the active words");

  a_update_ptr: assert property ( // R12
    $rose(frequency_update_strobe) |-> ##2 load_ptr_clear)
    else $error("Load pointer not cleared on update");

  a_reset_clear: assert property (@(posedge clk) disable iff (1'b0) // R13
    !rstn |=> acc_reg == `NCO_ACC_ZERO && ftw_reg == `NCO_ACC_ZERO
           && !pd_bit_reg)
    else $error("Reset did not clear the active state");

  a_slow_pd: assert property ( // R9
    !ref_edge [*8] ##1 (!ref_edge && mon_cnt_reg >= `NCO_MON_LIMIT)
    |=> power_down)
    else $error("Slow reference did not force power-down");

  a_resume_run: assert property ( // R10
    slow_reg && ref_edge && !pd_bit_reg && !upd_edge |=> !power_down)
    else $error("Power-down did not end on reference edge");

  a_dac_latency: assert property ( // R6
    ref_edge && !power_down |-> ##2 dac_out.valid)
    else $error("Sample not delivered two cycles after edge");

  a_phase_trunc: assert property ( // R15
    phase_next[`NCO_OFS_SHIFT-1:0]
      == acc_reg[`NCO_TRUNC_LSB+`NCO_OFS_SHIFT-1:`NCO_TRUNC_LSB]
    && phase_next[`NCO_PHASE_W-1:`NCO_OFS_SHIFT]
      == acc_reg[`NCO_ACC_W-1:`NCO_ACC_W-`NCO_OFS_W] + ofs_reg)
    else $error("Offset not added to the top phase bits");

  // Pointer, update, reset, sample stream and monitor checks
  a_ptr_single: assert property ( // R12
    load_ptr_clear |=> !load_ptr_clear)
    else $error("Load pointer clear held for more than one cycle");

  a_update_pd: assert property ( // R12
    upd_edge |=> pd_bit_reg == $past(prog_word.power_down))
    else $error("Update edge did not load the power-down bit");

  a_ftw_hold: assert property ( // R12
    !upd_edge |=> ftw_reg == $past(ftw_reg))
    else $error("Tuning word changed without an update edge");

  a_upd_no_jump: assert property ( // R7
    upd_edge && !ref_edge |=> acc_reg == $past(acc_reg))
    else $error("Update moved the accumulator");

  a_reset_quiet: assert property (@(posedge clk) disable iff (1'b0) // R13
    !rstn |=> ofs_reg == `NCO_OFS_ZERO && !power_down
           && !dac_out.valid)
    else $error("Reset did not clear offset, power-down or valid");

  a_valid_pulse: assert property ( // R6
    dac_out.valid |=> !dac_out.valid)
    else $error("Sample valid lasted more than one cycle");

  a_pd_no_sample: assert property ( // R9
    power_down |-> ##2 !dac_out.valid)
    else $error("Sample delivered during power-down");

  a_slow_hold: assert property ( // R9
    slow_reg && !ref_edge |=> slow_reg)
    else $error("Slow flag cleared without a reference edge");

  a_mon_bound: assert property ( // R9
    mon_cnt_reg <= `NCO_MON_LIMIT)
    else $error("Rate monitor counted past its limit");

  // Main scenarios: samples, wrap, auto power-down, updates, offset
  c_sample_out: cover property (dac_out.valid ##1 !dac_out.valid);
  c_wrap: cover property (ref_edge && !power_down ##1
                          acc_reg < $past(acc_reg));
  c_auto_pd: cover property ($rose(slow_reg));
  c_update: cover property (upd_edge);
  c_offset: cover property (upd_edge && prog_word.phase_ofs != `NCO_OFS_ZERO);
endmodule
`default_nettype wire

// ===== test/nco_ref_src.sv
// Reference clock source standing in for the outside oscillator
`timescale 1ns/1ps
`default_nettype none
module nco_ref_src (
  input  wire logic       clk,     // System clock
  input  wire logic       run,     // Oscillate while high
  input  wire logic [3:0] half,    // Half period in clk cycles
  output logic            ref_out  // Reference pin level
);
  logic [3:0] cnt_reg;
  // Stands low between bursts; short half periods keep the rate legal
  always_ff @(posedge clk) begin
    if (!run) begin
      cnt_reg <= 4'h0;
      ref_out <= 1'b0;
    end else if (cnt_reg + 4'h1 >= half) begin
      cnt_reg <= 4'h0;
      ref_out <= ~ref_out;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench for the oscillator core
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((e) !== (g)) begin \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); fails++; end end
module testbench
  import nco_pkg::*;
;
  logic        clk, rstn, strobe, run, ref_pin, lpc, pd;
  logic [3:0]  half;
  nco_prog_t   pw;
  nco_sample_t dac;
  logic [31:0] acc, exp_acc, tw_exp;
  int          fails, tests_run, cyc, i, k;
  nco_ref_src nco_ref_src_inst (.clk(clk), .run(run), .half(half),
    .ref_out(ref_pin));
  nco_core nco_core_inst (.clk(clk), .rstn(rstn),
    .reference_clock_in(ref_pin), .frequency_update_strobe(strobe),
    .prog_word(pw), .load_ptr_clear(lpc), .dac_out(dac),
    .power_down(pd), .phase_acc(acc));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic conclude;
    $display("Checks run %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      fails++;
      conclude();
    end
  end
  // Every sample must carry the accumulator advanced by one tuning word
  always @(negedge clk) if (dac.valid === 1'b1) begin
    exp_acc = exp_acc + tw_exp;
    `CHK("phase_acc", exp_acc, acc)
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Reference is paused briefly, well short of the monitor limit
  task automatic load(input logic [31:0] tw, input logic [4:0] ofs,
                      input logic pdn);
    logic hit;
    run = 1'b0;
    tick(2);
    pw = '{ofs, pdn, tw};
    strobe = 1'b1;
    hit = 1'b0;
    for (k = 0; k < 4; k++) begin
      tick(1);
      hit = hit | lpc;
    end
    `CHK("load_ptr_clear", 1'b1, hit)
    strobe = 1'b0;
    tick(2);
    pw = ~pw;
    tw_exp = tw;
    run = !pdn;
  endtask
  task automatic wait_valid;
    tick(1);
    for (k = 0; k < 30 && dac.valid !== 1'b1; k++) tick(1);
  endtask
  initial begin
    rstn = 1'b0;
    strobe = 1'b0;
    run = 1'b0;
    half = 4'h2;
    pw = '0;
    exp_acc = 32'h0;
    tw_exp = 32'h0;
    fails = 0;
    tests_run = 0;
    cyc = 0;
    void'($urandom(55043));
    tick(5);
    `CHK("reset acc", 32'h0, acc)
    `CHK("reset pd", 1'b0, pd)
    `CHK("reset code", 10'h200, dac.code)
    `CHK("reset lpc", 1'b1, lpc)
    rstn = 1'b1;
    load(32'h0, 5'h00, 1'b0);
    wait_valid();
    `CHK("cos peak", 10'h3FF, dac.code)
    load(32'h0, 5'h10, 1'b0);
    wait_valid();
    `CHK("cos offset", 1'b1, dac.code < 10'h010)
    for (i = 0; i < 12; i++) begin
      half = 4'(2 + $urandom % 3);
      load(i == 0 ? 32'hFFFF_FFF0 : $urandom % 32'h5555_5555, 5'h00,
           1'b0);
      tick(60);
    end
    load(tw_exp, 5'h00, 1'b1);
    tick(1);
    run = 1'b1;
    tick(40);
    `CHK("prog pd", 1'b1, pd)
    `CHK("frozen acc", exp_acc, acc)
    load(tw_exp, 5'h00, 1'b0);
    tick(1);
    run = 1'b0;
    for (k = 0; k < 30 && pd !== 1'b1; k++) tick(1);
    `CHK("auto pd", 1'b1, pd)
    run = 1'b1;
    for (k = 0; k < 20 && pd !== 1'b0; k++) tick(1);
    `CHK("auto wake", 1'b0, pd)
    tick(40);
    // Mid-run reset with nonzero words and power-down programmed
    load(32'h0123_4567, 5'h03, 1'b1);
    rstn = 1'b0;
    tick(5);
    `CHK("mid reset acc", 32'h0, acc)
    `CHK("mid reset pd", 1'b0, pd)
    `CHK("mid reset lpc", 1'b1, lpc)
    exp_acc = 32'h0;
    tw_exp = 32'h0;
    rstn = 1'b1;
    run = 1'b1;
    wait_valid();
    `CHK("mid reset code", 10'h3FF, dac.code)
    conclude();
  end
endmodule
`default_nettype wire
